// ### pmt_checker.sv
// port assertions for the power monitor
module pmt_chk #(
    parameter int REFRESH_CYCLES = pmt_pkg::REFRESH_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // watched ports
    input wire logic [7:0] conv_temp,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic battery_event,
    input wire logic over_heat_flag,
    input wire logic over_current_flag,
    input wire logic refresh_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    // edges since reset or the last pulse; a counter, as the period is long
    int gap_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap_q <= 0;
        end else if (refresh_pulse) begin
            gap_q <= 1;
        end else if (gap_q < REFRESH_CYCLES) begin
            gap_q <= gap_q + 1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence read_s;
        reg_rd ##1 reg_rvalid;
    endsequence
    sequence cold_s;
        (conv_temp == 8'h00) ##1 refresh_pulse;
    endsequence
    rd_answer_a: assert property (reg_rd |-> read_s)
        else $error("read strobe not answered");
    rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read valid without strobe");
    unmapped_zero_a: assert property (
        reg_rd && (reg_addr < 8'h51 || reg_addr > 8'h5D)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    refresh_period_a: assert property (
        refresh_pulse == (gap_q == REFRESH_CYCLES))
        else $error("refresh period wrong");
    refresh_single_a: assert property (refresh_pulse |=> !refresh_pulse)
        else $error("refresh pulse too long");
    battery_timing_a: assert property (
        battery_event |-> $past(refresh_pulse))
        else $error("battery event off refresh");
    heat_timing_a: assert property (
        over_heat_flag |-> $past(refresh_pulse))
        else $error("over heat flag off refresh");
    current_timing_a: assert property (
        over_current_flag |-> $past(refresh_pulse))
        else $error("over current flag off refresh");
    // a zero code can never exceed a limit
    cold_die_a: assert property (cold_s |=> !over_heat_flag)
        else $error("over heat flag on zero reading");
endmodule : pmt_chk

bind pmt_monitor pmt_chk #(.REFRESH_CYCLES(REFRESH_CYCLES)) i_chk (
    .sys_clk(sys_clk), .resetn(resetn), .conv_temp(conv_temp),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .battery_event(battery_event),
    .over_heat_flag(over_heat_flag), .over_current_flag(over_current_flag),
    .refresh_pulse(refresh_pulse));

// ### pmt_eval.sv
// threshold comparison and event pulses of the power monitor
module pmt_eval #(
    parameter logic [7:0] OTHER_LIMIT = pmt_pkg::RST_OTHER_LIM
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // refreshed readings and limits
    input wire logic evaluate,
    input wire logic [pmt_pkg::NUM_READINGS-1:0][7:0] reading,
    input wire logic [7:0] bat_low,
    input wire logic [7:0] bat_high,
    input wire logic [7:0] heat_lim,
    input wire logic [7:0] reg0_lim,
    input wire logic [7:0] reg1_lim,
    // event pulses
    output logic battery_event,
    output logic over_heat_flag,
    output logic over_current_flag
);
    import pmt_pkg::*;

    typedef struct packed {
        logic battery;
        logic heat;
        logic current;
    } pmt_eval_t;

    pmt_eval_t s_q;
    pmt_eval_t s_d;
    logic bat_below;
    logic bat_above;
    logic cur_trip;

    // strict compare: a reading equal to its limit is not a violation
    function automatic logic pmt_over(input logic [7:0] val,
                                      input logic [7:0] lim);
        pmt_over = val > lim;
    endfunction : pmt_over

    always_comb begin
        // R2: battery below low
        bat_below = reading[CH_BATTERY] < bat_low;
        // R3: battery above high
        bat_above = pmt_over(reading[CH_BATTERY], bat_high);
        // R12: any regulator over limit
        cur_trip = pmt_over(reading[CH_REG0], reg0_lim)
            | pmt_over(reading[CH_REG1], reg1_lim)
            | pmt_over(reading[CH_REG2], OTHER_LIMIT)
            | pmt_over(reading[CH_REG3], OTHER_LIMIT)
            | pmt_over(reading[CH_REG0A], OTHER_LIMIT);
        s_d = '0;
        // R13: judged on every refresh
        if (evaluate) begin
            s_d.battery = bat_below | bat_above;
            // R4: over-heat compare
            // R11: over-heat event
            s_d.heat = pmt_over(reading[CH_TEMP], heat_lim);
            s_d.current = cur_trip;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // R1: events toward the interrupt controller
    assign battery_event = s_q.battery;
    assign over_heat_flag = s_q.heat;
    assign over_current_flag = s_q.current;

endmodule : pmt_eval

// ### pmt_monitor.sv
// power monitor: readings, limit registers and threshold events
// Overview of operation
// R1: holds reading and limit registers, raises events when a limit is crossed.
// R2: battery reading below low limit raises the battery event.
// R3: battery reading above high limit raises the battery event.
// R4: die temperature above over-heat limit raises the over-heat event.
// R5: die temperature reading is a raw 8-bit converter code.
// R6: system supply reading is a raw 8-bit converter code.
// R7: battery reading is a raw 8-bit converter code.
// R8: each regulator current reading is a raw 8-bit converter code.
// R9: software scales battery limits with the battery reading scale.
// R10: software leaves both regulator current limits at reset value.
// R11: over-heat violation sets the over-heat flag toward interrupts.
// R12: any regulator over its limit sets the over-current flag.
// R13: readings refresh periodically; every refresh re-evaluates all limits.
module pmt_monitor #(
    parameter int REFRESH_CYCLES = pmt_pkg::REFRESH_CYCLES,
    parameter logic [7:0] OTHER_LIMIT = pmt_pkg::RST_OTHER_LIM
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // converter results, same clock domain
    input wire logic [7:0] conv_temp,
    input wire logic [7:0] conv_supply,
    input wire logic [7:0] conv_battery,
    input wire logic [7:0] conv_reg0,
    input wire logic [7:0] conv_reg1,
    input wire logic [7:0] conv_reg2,
    input wire logic [7:0] conv_reg3,
    input wire logic [7:0] conv_reg0a,
    // register port from the serial host interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // events toward the interrupt controller
    output logic battery_event,
    output logic over_heat_flag,
    output logic over_current_flag,
    output logic refresh_pulse
);
    import pmt_pkg::*;

    // the counter runs down to zero and reloads, independent of the host
    localparam int CNT_W = (REFRESH_CYCLES > 1) ? $clog2(REFRESH_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(REFRESH_CYCLES - 1);

    typedef struct packed {
        logic [NUM_READINGS-1:0][7:0] reading;
        logic [7:0] bat_low;
        logic [7:0] bat_high;
        logic [7:0] heat_lim;
        logic [7:0] reg0_lim;
        logic [7:0] reg1_lim;
        logic [CNT_W-1:0] tick_cnt;
        logic refresh;
        // rdata holds the last answer until the next read
        logic [7:0] rdata;
        logic rvalid;
    } pmt_state_t;

    // which writable limit an offset names; one bit at most is set
    typedef struct packed {
        logic bat_low;
        logic bat_high;
        logic heat_lim;
        logic reg0_lim;
        logic reg1_lim;
    } pmt_lim_sel_t;

    pmt_state_t s_q;
    pmt_state_t s_d;
    logic [NUM_READINGS-1:0][7:0] conv_all;
    pmt_lim_sel_t lim_sel;

    // reading registers occupy one contiguous run of offsets
    function automatic logic pmt_is_reading(input logic [7:0] addr);
        pmt_is_reading = (addr >= ADDR_TEMP) && (addr <= ADDR_REG0A_CUR);
    endfunction : pmt_is_reading

    function automatic logic [2:0] pmt_reading_idx(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - ADDR_TEMP;
        pmt_reading_idx = diff[2:0];
    endfunction : pmt_reading_idx

    // shared by the write and the read path so the two maps cannot drift
    function automatic pmt_lim_sel_t pmt_limit_sel(input logic [7:0] addr);
        pmt_lim_sel_t sel;
        sel = '0;
        unique case (addr)
            ADDR_BAT_LOW: sel.bat_low = 1'b1;
            ADDR_BAT_HIGH: sel.bat_high = 1'b1;
            ADDR_HEAT_LIM: sel.heat_lim = 1'b1;
            ADDR_REG0_LIM: sel.reg0_lim = 1'b1;
            ADDR_REG1_LIM: sel.reg1_lim = 1'b1;
            default: begin
            end
        endcase
        pmt_limit_sel = sel;
    endfunction : pmt_limit_sel

    // gathered so that one assignment captures all channels together
    assign conv_all[CH_TEMP] = conv_temp;
    assign conv_all[CH_SUPPLY] = conv_supply;
    assign conv_all[CH_BATTERY] = conv_battery;
    assign conv_all[CH_REG0] = conv_reg0;
    assign conv_all[CH_REG1] = conv_reg1;
    assign conv_all[CH_REG2] = conv_reg2;
    assign conv_all[CH_REG3] = conv_reg3;
    assign conv_all[CH_REG0A] = conv_reg0a;

    assign lim_sel = pmt_limit_sel(reg_addr);

    always_comb begin
        s_d = s_q;
        s_d.refresh = 1'b0;
        s_d.rvalid = 1'b0;

        // R13: periodic refresh timer
        if (s_q.tick_cnt == '0) begin
            s_d.tick_cnt = CNT_LOAD;
            s_d.refresh = 1'b1;
            // R5: raw codes are stored, software applies the scale
            // R6: supply code stored as is
            // R7: battery code stored as is
            // R8: current codes stored as is
            s_d.reading = conv_all;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt - 1'b1;
        end

        // R1: limit register writes; readings ignore writes
        if (reg_wr) begin
            // a reading offset matches none of these, so its write is dropped
            if (lim_sel.bat_low) begin
                s_d.bat_low = reg_wdata;
            end
            if (lim_sel.bat_high) begin
                s_d.bat_high = reg_wdata;
            end
            if (lim_sel.heat_lim) begin
                s_d.heat_lim = reg_wdata;
            end
            if (lim_sel.reg0_lim) begin
                s_d.reg0_lim = reg_wdata;
            end
            if (lim_sel.reg1_lim) begin
                s_d.reg1_lim = reg_wdata;
            end
        end

        // R1: register read, unmapped offsets read zero
        if (reg_rd) begin
            s_d.rvalid = 1'b1;
            // the old value is read when a write meets it in one cycle
            s_d.rdata = RDATA_NONE;
            if (pmt_is_reading(reg_addr)) begin
                s_d.rdata = s_q.reading[pmt_reading_idx(reg_addr)];
            end
            if (lim_sel.bat_low) begin
                s_d.rdata = s_q.bat_low;
            end
            if (lim_sel.bat_high) begin
                s_d.rdata = s_q.bat_high;
            end
            if (lim_sel.heat_lim) begin
                s_d.rdata = s_q.heat_lim;
            end
            if (lim_sel.reg0_lim) begin
                s_d.rdata = s_q.reg0_lim;
            end
            if (lim_sel.reg1_lim) begin
                s_d.rdata = s_q.reg1_lim;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            // readings show zero until the first refresh captures them
            s_q.reading <= {NUM_READINGS{RST_READING}};
            s_q.bat_low <= RST_BAT_LOW;
            s_q.bat_high <= RST_BAT_HIGH;
            s_q.heat_lim <= RST_HEAT_LIM;
            // R10: current limits come up at safe defaults
            s_q.reg0_lim <= RST_CUR_LIM;
            s_q.reg1_lim <= RST_CUR_LIM;
            s_q.tick_cnt <= CNT_LOAD;
            s_q.refresh <= 1'b0;
            s_q.rdata <= RDATA_NONE;
            s_q.rvalid <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // comparisons see the readings one cycle after capture
    pmt_eval #(
        .OTHER_LIMIT(OTHER_LIMIT)
    ) u_eval (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .evaluate(s_q.refresh),
        .reading(s_q.reading),
        .bat_low(s_q.bat_low),
        .bat_high(s_q.bat_high),
        .heat_lim(s_q.heat_lim),
        .reg0_lim(s_q.reg0_lim),
        .reg1_lim(s_q.reg1_lim),
        .battery_event(battery_event),
        .over_heat_flag(over_heat_flag),
        .over_current_flag(over_current_flag)
    );

    assign reg_rdata = s_q.rdata;
    assign reg_rvalid = s_q.rvalid;
    assign refresh_pulse = s_q.refresh;

endmodule : pmt_monitor

// ### pmt_pkg.sv
// constants shared by the power monitor threshold block
package pmt_pkg;

    // register offsets on the internal register port
    localparam logic [7:0] ADDR_TEMP = 8'h51;
    localparam logic [7:0] ADDR_SUPPLY = 8'h52;
    localparam logic [7:0] ADDR_BATTERY = 8'h53;
    localparam logic [7:0] ADDR_REG0_CUR = 8'h54;
    localparam logic [7:0] ADDR_REG1_CUR = 8'h55;
    localparam logic [7:0] ADDR_REG2_CUR = 8'h56;
    localparam logic [7:0] ADDR_REG3_CUR = 8'h57;
    localparam logic [7:0] ADDR_REG0A_CUR = 8'h58;
    localparam logic [7:0] ADDR_BAT_LOW = 8'h59;
    localparam logic [7:0] ADDR_BAT_HIGH = 8'h5A;
    localparam logic [7:0] ADDR_HEAT_LIM = 8'h5B;
    localparam logic [7:0] ADDR_REG0_LIM = 8'h5C;
    localparam logic [7:0] ADDR_REG1_LIM = 8'h5D;

    // reading channels, in register order from the temperature reading
    localparam int NUM_READINGS = 8;
    localparam int CH_TEMP = 0;
    localparam int CH_SUPPLY = 1;
    localparam int CH_BATTERY = 2;
    localparam int CH_REG0 = 3;
    localparam int CH_REG1 = 4;
    localparam int CH_REG2 = 5;
    localparam int CH_REG3 = 6;
    localparam int CH_REG0A = 7;

    // reset values
    localparam logic [7:0] RST_READING = 8'h00;
    localparam logic [7:0] RST_BAT_LOW = 8'h00;
    localparam logic [7:0] RST_BAT_HIGH = 8'hFF;
    localparam logic [7:0] RST_HEAT_LIM = 8'hFF;
    localparam logic [7:0] RST_CUR_LIM = 8'hFF;
    localparam logic [7:0] RST_OTHER_LIM = 8'hFF;
    localparam logic [7:0] RDATA_NONE = 8'h00;

    // timing
    localparam int CLK_FREQ_HZ = 10_000_000;
    localparam int REFRESH_PERIOD_US = 1000;
    localparam int REFRESH_CYCLES = REFRESH_PERIOD_US
        * (CLK_FREQ_HZ / 1_000_000);

endpackage : pmt_pkg

// ### pmt_tb.sv
// self-checking bench for the power monitor
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pmt_pkg::*;
    // short refresh keeps the run brief
    localparam int RC = 8;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] conv_temp, conv_supply, conv_battery, conv_reg0, conv_reg1;
    logic [7:0] conv_reg2, conv_reg3, conv_reg0a, reg_addr, reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_wr, reg_rd, reg_rvalid, refresh_pulse;
    logic battery_event, over_heat_flag, over_current_flag;
    int bad_count = 0;
    int num_checks = 0;
    always #50 sys_clk = ~sys_clk;
    pmt_monitor #(.REFRESH_CYCLES(RC), .OTHER_LIMIT(8'h80)) i_dut (
        .sys_clk(sys_clk), .resetn(resetn), .conv_temp(conv_temp),
        .conv_supply(conv_supply), .conv_battery(conv_battery),
        .conv_reg0(conv_reg0), .conv_reg1(conv_reg1), .conv_reg2(conv_reg2),
        .conv_reg3(conv_reg3), .conv_reg0a(conv_reg0a), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .battery_event(battery_event), .over_heat_flag(over_heat_flag),
        .over_current_flag(over_current_flag), .refresh_pulse(refresh_pulse));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        check({7'h00, reg_rvalid}, 8'h01);
        check(reg_rdata, exp);
    endtask : rd
    // waits for a refresh, then judges the event pulses that follow it
    task automatic step(input logic [2:0] exp);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (refresh_pulse !== 1'b1 && n < 40);
        if (refresh_pulse !== 1'b1) begin
            bad_count++;
            final_report();
        end else begin
            @(negedge sys_clk);
            check({5'h00, battery_event, over_heat_flag, over_current_flag},
                {5'h00, exp});
        end
    endtask : step
    task automatic t_reset;
        logic [7:0] e;
        for (int a = 8'h50; a < 8'h5F; a++) begin
            e = (a > 8'h50 && a < 8'h59) ? RST_READING : RDATA_NONE;
            e = (a == 8'h59) ? RST_BAT_LOW : (a == 8'h5A) ? RST_BAT_HIGH : e;
            e = (a == 8'h5B) ? RST_HEAT_LIM : (a > 8'h5B && a < 8'h5E)
                ? RST_CUR_LIM : e;
            rd(a[7:0], e);
        end
        wr(ADDR_TEMP, 8'hAA);
        wr(8'h5E, 8'hAA);
        rd(ADDR_TEMP, RST_READING);
        rd(8'h5E, RDATA_NONE);
        step(3'b000);
    endtask : t_reset
    task automatic t_battery;
        // limits coded on the battery scale
        wr(ADDR_BAT_LOW, 8'h40);
        wr(ADDR_BAT_HIGH, 8'hC0);
        conv_battery = 8'h3F;
        step(3'b100);
        step(3'b100);
        conv_battery = 8'h40;
        step(3'b000);
        conv_battery = 8'hC1;
        step(3'b100);
        conv_battery = 8'hC0;
        step(3'b000);
        rd(ADDR_BATTERY, 8'hC0);
    endtask : t_battery
    task automatic t_heat;
        conv_battery = 8'h80;
        conv_temp = 8'h81;
        conv_supply = 8'hA5;
        wr(ADDR_HEAT_LIM, 8'h80);
        step(3'b010);
        step(3'b010);
        conv_temp = 8'h80;
        step(3'b000);
        rd(ADDR_TEMP, 8'h80);
        rd(ADDR_SUPPLY, 8'hA5);
    endtask : t_heat
    task automatic t_current;
        // regulator 0 and 1 limits stay at reset
        conv_reg0 = 8'hFF;
        conv_reg1 = 8'hFF;
        conv_reg2 = 8'h81;
        step(3'b001);
        conv_reg2 = 8'h80;
        conv_reg3 = 8'h81;
        step(3'b001);
        conv_reg3 = 8'h80;
        conv_reg0a = 8'h81;
        step(3'b001);
        conv_reg0a = 8'h80;
        step(3'b000);
        rd(ADDR_REG0_LIM, RST_CUR_LIM);
        rd(ADDR_REG0_CUR, 8'hFF);
        rd(ADDR_REG0A_CUR, 8'h80);
    endtask : t_current
    initial begin
        {conv_temp, conv_supply, conv_battery, conv_reg0} = 32'h0;
        {conv_reg1, conv_reg2, conv_reg3, conv_reg0a} = 32'h0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
        t_reset();
        t_battery();
        t_heat();
        t_current();
        final_report();
    end
endmodule : tb
